// [cmp_exec_pkg.sv]
// constants, encodings and carrier types of the compare/clear/invert/adjust/decrement slice
// assumes an 8-bit core with a 16-bit program counter and a synchronous data memory path
// ----------------------------------------------------------------
// Summary of operation
// - compare: pc moves past 3 bytes, then adds signed displacement if unequal
// - compare: carry set when first operand unsigned-less than second; operands untouched
// - compare forms b5h, b4h, b8h+reg, b6h+pointer; 3 bytes, 4, 3, 4 and 6 cycles
// - clear accumulator zeroes it, flags untouched, one byte, one cycle
// - clear carry c3h one byte, clear bit c2h two bytes; only target changes
// - invert accumulator f4h gives ones' complement, flags untouched
// - invert carry b3h one byte, invert bit b2h two bytes; only target changes
// - read-modify-write of a port reads the output latch, not the pins
// - adjust: low nibble above 9 or aux carry adds 6; carry out only sets carry
// - adjust: carry or high nibble above 9 adds 6 to high nibble; overflow untouched
// - adjust d4h single cycle, net addition 00h, 06h, 60h or 66h
// - decrement subtracts one, 00h wraps to ffh, flags untouched
// - decrement forms 14h, 18h+reg, 15h+address, 16h+pointer; 1, 3, 3 and 5 cycles
// ----------------------------------------------------------------
package cmp_exec_pkg;

   // ----------------------------------------------------------------
   // opcodes
   // ----------------------------------------------------------------
   localparam logic [7:0] OP_CMP_DIRECT = 8'hb5;
   localparam logic [7:0] OP_CMP_IMM = 8'hb4;
   localparam logic [7:0] OP_CMP_REG = 8'hb8;
   localparam logic [7:0] OP_CMP_IND = 8'hb6;
   localparam logic [7:0] OP_CLR_ACC = 8'he4;
   localparam logic [7:0] OP_CLR_CARRY = 8'hc3;
   localparam logic [7:0] OP_CLR_BIT = 8'hc2;
   localparam logic [7:0] OP_INV_ACC = 8'hf4;
   localparam logic [7:0] OP_INV_CARRY = 8'hb3;
   localparam logic [7:0] OP_INV_BIT = 8'hb2;
   localparam logic [7:0] OP_ADJUST = 8'hd4;
   localparam logic [7:0] OP_DEC_ACC = 8'h14;
   localparam logic [7:0] OP_DEC_DIRECT = 8'h15;
   localparam logic [7:0] OP_DEC_REG = 8'h18;
   localparam logic [7:0] OP_DEC_IND = 8'h16;
   localparam logic [7:0] MASK_REG_FORM = 8'hf8;
   localparam logic [7:0] MASK_IND_FORM = 8'hfe;

   // ----------------------------------------------------------------
   // lengths, bcd figures, address map
   // ----------------------------------------------------------------
   localparam logic [15:0] LEN_ONE = 16'h0001;
   localparam logic [15:0] LEN_TWO = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;
   localparam logic [3:0] BCD_LIMIT = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;
   localparam logic [7:0] BIT_AREA_BASE = 8'h20;
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] SFR_BIT_MASK = 8'hf8;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [15:0] PC_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic carry_flag;
      logic aux_carry_flag;
      logic signed_wrap_flag;
   } program_flags_word_type;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
   } instr_type;

   typedef struct packed {
      logic [7:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
      logic from_latch;
   } mem_req_type;

   typedef enum logic [3:0] {
      K_NONE = 4'h0,
      K_CMP = 4'h1,
      K_CLR_BIT = 4'h2,
      K_INV_BIT = 4'h3,
      K_DEC_MEM = 4'h4
   } op_kind_type;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_PTR_REQ = 3'b001,
      S_PTR_DATA = 3'b010,
      S_OPD_REQ = 3'b011,
      S_OPD_DATA = 3'b100,
      S_BRANCH = 3'b101
   } state_type;

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   function automatic logic [7:0] minus_one(input logic [7:0] value);
      minus_one = value - 8'h01;
   endfunction : minus_one

   function automatic logic [7:0] bit_byte_addr(input logic [7:0] bit_addr);
      if (bit_addr < SFR_BASE) begin
         bit_byte_addr = BIT_AREA_BASE + {4'h0, bit_addr[6:3]};
      end else begin
         bit_byte_addr = bit_addr & SFR_BIT_MASK;
      end
   endfunction : bit_byte_addr

endpackage : cmp_exec_pkg

// [decimal_adjust.sv]
// packed-bcd correction of the accumulator after an addition
// assumes the carry and aux carry left by the preceding addition
`timescale 1ns/1ps
module decimal_adjust
   import cmp_exec_pkg::*;
(
   // operands
   input wire logic [7:0] acc,
   input wire logic carry_in,
   input wire logic aux_in,
   // result
   output logic [7:0] result,
   output logic carry_out
);
   logic [8:0] low_sum;
   logic [7:0] low_acc;
   logic low_carry;
   logic [4:0] high_sum;

   always_comb begin
      low_sum = {1'b0, acc};
      if ((acc[3:0] > BCD_LIMIT) || aux_in) begin
         low_sum = {1'b0, acc} + {5'h00, BCD_FIX};
      end
      low_acc = low_sum[7:0];
      low_carry = carry_in | low_sum[8];
      high_sum = {1'b0, low_acc[7:4]};
      if ((low_acc[7:4] > BCD_LIMIT) || low_carry) begin
         high_sum = {1'b0, low_acc[7:4]} + {1'b0, BCD_FIX};
      end
      result = {high_sum[3:0], low_acc[3:0]};
      carry_out = low_carry | high_sum[4];
   end
endmodule : decimal_adjust

// [cmp_clear_cpl_bcd_dec_exec.sv]
// executes compare-branch, clear, invert, decimal adjust and decrement
// assumes a synchronous data memory: read data valid the cycle after a read strobe
`timescale 1ns/1ps
module cmp_clear_cpl_bcd_dec_exec
   import cmp_exec_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // instruction stream
   input wire logic instr_valid,
   input wire instr_type instr,
   input wire logic [1:0] bank_register_sel,
   output logic instr_ready,
   output logic done,
   output logic unsupported,
   // core state load
   input wire logic load_valid,
   input wire logic [7:0] load_acc,
   input wire program_flags_word_type load_flags,
   input wire logic [15:0] load_pc,
   // data memory path
   output mem_req_type mem_req,
   input wire logic [7:0] mem_rdata,
   // core state
   output logic [7:0] acc,
   output program_flags_word_type flags,
   output logic [15:0] pc
);
   state_type state_reg, state_next;
   op_kind_type kind_reg, kind_next;
   logic [7:0] acc_reg, acc_next;
   program_flags_word_type flags_reg, flags_next;
   logic [15:0] pc_reg, pc_next;
   mem_req_type mem_reg, mem_next;
   logic [7:0] imm_reg, imm_next;
   logic [7:0] disp_reg, disp_next;
   logic [2:0] bit_idx_reg, bit_idx_next;
   logic lhs_acc_reg, lhs_acc_next;
   logic rhs_mem_reg, rhs_mem_next;
   logic unequal_reg, unequal_next;
   logic ready_reg, done_reg, done_next, unsup_reg, unsup_next;
   logic [7:0] adj_result;
   logic adj_carry;
   logic [7:0] lhs, rhs, bit_mask;
   logic take;

   decimal_adjust adjust_unit (
      .acc(acc_reg),
      .carry_in(flags_reg.carry_flag),
      .aux_in(flags_reg.aux_carry_flag),
      .result(adj_result),
      .carry_out(adj_carry)
   );

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      kind_next = kind_reg;
      acc_next = acc_reg;
      flags_next = flags_reg;
      pc_next = pc_reg;
      mem_next = mem_reg;
      mem_next.rd = 1'b0;
      mem_next.wr = 1'b0;
      imm_next = imm_reg;
      disp_next = disp_reg;
      bit_idx_next = bit_idx_reg;
      lhs_acc_next = lhs_acc_reg;
      rhs_mem_next = rhs_mem_reg;
      unequal_next = unequal_reg;
      done_next = 1'b0;
      unsup_next = 1'b0;
      take = instr_valid && ready_reg && !load_valid;
      lhs = lhs_acc_reg ? acc_reg : mem_rdata;
      rhs = rhs_mem_reg ? mem_rdata : imm_reg;
      bit_mask = 8'h01 << bit_idx_reg;
      case (state_reg)
         S_IDLE: begin
            if (load_valid) begin
               acc_next = load_acc;
               flags_next = load_flags;
               pc_next = load_pc;
            end else if (take) begin
               kind_next = K_NONE;
               imm_next = instr.byte1;
               disp_next = instr.byte2;
               bit_idx_next = instr.byte1[2:0];
               lhs_acc_next = 1'b0;
               rhs_mem_next = 1'b0;
               mem_next.from_latch = 1'b0;
               done_next = 1'b1;
               if (instr.opcode == OP_CLR_ACC) begin
                  acc_next = ACC_RESET;
                  pc_next = pc_reg + LEN_ONE;
               end else if (instr.opcode == OP_INV_ACC) begin
                  acc_next = ~acc_reg;
                  pc_next = pc_reg + LEN_ONE;
               end else if (instr.opcode == OP_CLR_CARRY) begin
                  flags_next.carry_flag = 1'b0;
                  pc_next = pc_reg + LEN_ONE;
               end else if (instr.opcode == OP_INV_CARRY) begin
                  flags_next.carry_flag = ~flags_reg.carry_flag;
                  pc_next = pc_reg + LEN_ONE;
               end else if (instr.opcode == OP_ADJUST) begin
                  acc_next = adj_result;
                  flags_next.carry_flag = adj_carry;
                  pc_next = pc_reg + LEN_ONE;
               end else if (instr.opcode == OP_DEC_ACC) begin
                  acc_next = minus_one(acc_reg);
                  pc_next = pc_reg + LEN_ONE;
               end else if (instr.opcode == OP_CLR_BIT || instr.opcode == OP_INV_BIT) begin
                  kind_next = (instr.opcode == OP_CLR_BIT) ? K_CLR_BIT : K_INV_BIT;
                  mem_next.addr = bit_byte_addr(instr.byte1);
                  mem_next.rd = 1'b1;
                  mem_next.from_latch = 1'b1;
                  pc_next = pc_reg + LEN_TWO;
                  done_next = 1'b0;
                  state_next = S_OPD_REQ;
               end else if (instr.opcode == OP_DEC_DIRECT) begin
                  kind_next = K_DEC_MEM;
                  mem_next.addr = instr.byte1;
                  mem_next.rd = 1'b1;
                  mem_next.from_latch = 1'b1;
                  pc_next = pc_reg + LEN_TWO;
                  done_next = 1'b0;
                  state_next = S_OPD_REQ;
               end else if ((instr.opcode & MASK_REG_FORM) == OP_DEC_REG) begin
                  kind_next = K_DEC_MEM;
                  mem_next.addr = {3'b000, bank_register_sel, instr.opcode[2:0]};
                  mem_next.rd = 1'b1;
                  pc_next = pc_reg + LEN_ONE;
                  done_next = 1'b0;
                  state_next = S_OPD_REQ;
               end else if ((instr.opcode & MASK_IND_FORM) == OP_DEC_IND) begin
                  kind_next = K_DEC_MEM;
                  mem_next.addr = {3'b000, bank_register_sel, 2'b00, instr.opcode[0]};
                  mem_next.rd = 1'b1;
                  pc_next = pc_reg + LEN_ONE;
                  done_next = 1'b0;
                  state_next = S_PTR_REQ;
               end else if (instr.opcode == OP_CMP_IMM) begin
                  kind_next = K_CMP;
                  lhs_acc_next = 1'b1;
                  pc_next = pc_reg + LEN_THREE;
                  done_next = 1'b0;
                  state_next = S_OPD_DATA;
               end else if (instr.opcode == OP_CMP_DIRECT) begin
                  kind_next = K_CMP;
                  lhs_acc_next = 1'b1;
                  rhs_mem_next = 1'b1;
                  mem_next.addr = instr.byte1;
                  mem_next.rd = 1'b1;
                  pc_next = pc_reg + LEN_THREE;
                  done_next = 1'b0;
                  state_next = S_OPD_REQ;
               end else if ((instr.opcode & MASK_REG_FORM) == OP_CMP_REG) begin
                  kind_next = K_CMP;
                  mem_next.addr = {3'b000, bank_register_sel, instr.opcode[2:0]};
                  mem_next.rd = 1'b1;
                  pc_next = pc_reg + LEN_THREE;
                  done_next = 1'b0;
                  state_next = S_OPD_REQ;
               end else if ((instr.opcode & MASK_IND_FORM) == OP_CMP_IND) begin
                  kind_next = K_CMP;
                  mem_next.addr = {3'b000, bank_register_sel, 2'b00, instr.opcode[0]};
                  mem_next.rd = 1'b1;
                  pc_next = pc_reg + LEN_THREE;
                  done_next = 1'b0;
                  state_next = S_PTR_REQ;
               end else begin
                  done_next = 1'b0;
                  unsup_next = 1'b1;
               end
            end
         end
         S_PTR_REQ: begin
            state_next = S_PTR_DATA;
         end
         S_PTR_DATA: begin
            mem_next.addr = mem_rdata;
            mem_next.rd = 1'b1;
            state_next = S_OPD_REQ;
         end
         S_OPD_REQ: begin
            state_next = S_OPD_DATA;
         end
         S_OPD_DATA: begin
            state_next = S_IDLE;
            done_next = 1'b1;
            case (kind_reg)
               K_CMP: begin
                  flags_next.carry_flag = (lhs < rhs);
                  unequal_next = (lhs != rhs);
                  done_next = 1'b0;
                  state_next = S_BRANCH;
               end
               K_CLR_BIT: begin
                  mem_next.wdata = mem_rdata & ~bit_mask;
                  mem_next.wr = 1'b1;
               end
               K_INV_BIT: begin
                  mem_next.wdata = mem_rdata ^ bit_mask;
                  mem_next.wr = 1'b1;
               end
               K_DEC_MEM: begin
                  mem_next.wdata = minus_one(mem_rdata);
                  mem_next.wr = 1'b1;
               end
               default: begin
                  mem_next.wr = 1'b0;
               end
            endcase
         end
         S_BRANCH: begin
            if (unequal_reg) begin
               pc_next = pc_reg + {{8{disp_reg[7]}}, disp_reg};
            end
            done_next = 1'b1;
            state_next = S_IDLE;
         end
         default: begin
            state_next = S_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= S_IDLE;
         kind_reg <= K_NONE;
         acc_reg <= ACC_RESET;
         flags_reg <= '0;
         pc_reg <= PC_RESET;
         mem_reg <= '0;
         imm_reg <= 8'h00;
         disp_reg <= 8'h00;
         bit_idx_reg <= 3'h0;
         lhs_acc_reg <= 1'b0;
         rhs_mem_reg <= 1'b0;
         unequal_reg <= 1'b0;
         ready_reg <= 1'b0;
         done_reg <= 1'b0;
         unsup_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         kind_reg <= kind_next;
         acc_reg <= acc_next;
         flags_reg <= flags_next;
         pc_reg <= pc_next;
         mem_reg <= mem_next;
         imm_reg <= imm_next;
         disp_reg <= disp_next;
         bit_idx_reg <= bit_idx_next;
         lhs_acc_reg <= lhs_acc_next;
         rhs_mem_reg <= rhs_mem_next;
         unequal_reg <= unequal_next;
         ready_reg <= (state_next == S_IDLE);
         done_reg <= done_next;
         unsup_reg <= unsup_next;
      end
   end

   assign instr_ready = ready_reg;
   assign done = done_reg;
   assign unsupported = unsup_reg;
   assign mem_req = mem_reg;
   assign acc = acc_reg;
   assign flags = flags_reg;
   assign pc = pc_reg;
endmodule : cmp_clear_cpl_bcd_dec_exec

// [cmp_exec_asserts.sv]
// checker for the compare/clear/invert/adjust/decrement slice
// assumes only the top module's ports; bound at the foot of this file
`timescale 1ns/1ps
module cmp_exec_asserts
   import cmp_exec_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic reset,
   // instruction stream
   input wire logic instr_valid,
   input wire instr_type instr,
   input wire logic instr_ready,
   input wire logic done,
   input wire logic unsupported,
   input wire logic load_valid,
   // memory and state
   input wire mem_req_type mem_req,
   input wire logic [7:0] acc,
   input wire program_flags_word_type flags,
   input wire logic [15:0] pc
);
   logic take;
   logic [7:0] op;
   assign take = instr_valid && instr_ready && !load_valid;
   assign op = instr.opcode;

   function automatic logic in_slice(input logic [7:0] o);
      in_slice = (o inside {OP_CMP_DIRECT, OP_CMP_IMM, OP_CLR_ACC, OP_CLR_CARRY, OP_CLR_BIT, OP_INV_ACC,
         OP_INV_CARRY, OP_INV_BIT, OP_ADJUST, OP_DEC_ACC, OP_DEC_DIRECT})
         || ((o & MASK_REG_FORM) inside {OP_CMP_REG, OP_DEC_REG})
         || ((o & MASK_IND_FORM) inside {OP_CMP_IND, OP_DEC_IND});
   endfunction : in_slice

   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);

   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence single_done;
      done && pc == $past(pc) + LEN_ONE && flags.signed_wrap_flag == $past(flags.signed_wrap_flag);
   endsequence
   sequence cmp_imm_end;
      !done ##1 !done ##1 done && flags.carry_flag == ($past(acc, 3) < $past(instr.byte1, 3)) && acc == $past(acc, 3)
         && pc == $past(pc, 3) + LEN_THREE + (($past(acc, 3) != $past(instr.byte1, 3))
         ? {{8{$past(instr.byte2[7], 3)}}, $past(instr.byte2, 3)} : 16'h0000);
   endsequence

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   a_clr_acc_zero: assert property (take && op == OP_CLR_ACC |=> single_done ##0
      acc == ACC_RESET && flags == $past(flags)) else $error("clear accumulator wrong");
   a_inv_acc_flip: assert property (take && op == OP_INV_ACC |=> single_done ##0
      acc == ~$past(acc) && flags == $past(flags)) else $error("invert accumulator wrong");
   a_clr_carry_only: assert property (take && op == OP_CLR_CARRY |=> single_done ##0 !flags.carry_flag
      && flags.aux_carry_flag == $past(flags.aux_carry_flag) && acc == $past(acc)) else $error("clear carry wrong");
   a_inv_carry_only: assert property (take && op == OP_INV_CARRY |=> single_done ##0
      flags.carry_flag != $past(flags.carry_flag) && acc == $past(acc)) else $error("invert carry wrong");
   a_dec_acc_wrap: assert property (take && op == OP_DEC_ACC |=> single_done ##0
      acc == $past(acc) - 8'h01 && flags == $past(flags)) else $error("decrement accumulator wrong");
   a_adjust_carry_kept: assert property (take && op == OP_ADJUST && flags.carry_flag |=>
      single_done ##0 flags.carry_flag) else $error("adjust cleared carry");
   a_cmp_imm_result: assert property (take && op == OP_CMP_IMM |=> cmp_imm_end)
      else $error("compare immediate wrong");
   a_dec_mem_latch: assert property (take && op == OP_DEC_DIRECT |=> mem_req.rd && mem_req.from_latch
      && mem_req.addr == $past(instr.byte1) ##[1:3] mem_req.wr && done) else $error("direct decrement wrong");
   a_unsup_no_effect: assert property (take && !in_slice(op) |=> unsupported && !done
      && pc == $past(pc) && acc == $past(acc)) else $error("unknown opcode had effect");
endmodule : cmp_exec_asserts

bind cmp_clear_cpl_bcd_dec_exec cmp_exec_asserts u_asserts (.clock(clock), .reset(reset),
   .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready), .done(done), .unsupported(unsupported),
   .load_valid(load_valid), .mem_req(mem_req), .acc(acc), .flags(flags), .pc(pc));

// [data_mem_model.sv]
// data memory partner: read data one cycle after the strobe
// assumes the slice's mem_req carrier and a single clock
`timescale 1ns/1ps
module data_mem_model
   import cmp_exec_pkg::*;
(
   // clock
   input wire logic clock,
   // request and answer
   input wire mem_req_type mem_req,
   output logic [7:0] mem_rdata
);
   logic [7:0] ram [0:255];
   initial mem_rdata = 8'h00;
   always @(posedge clock) begin
      if (mem_req.wr) begin
         ram[mem_req.addr] <= mem_req.wdata;
      end
      if (mem_req.rd && mem_req.addr >= SFR_BASE && !mem_req.from_latch) begin
         mem_rdata <= ~ram[mem_req.addr];
      end else if (mem_req.rd) begin
         mem_rdata <= ram[mem_req.addr];
      end else begin
         mem_rdata <= ~mem_rdata;
      end
   end
endmodule : data_mem_model

// [tb_top.sv]
// self-checking bench for the compare/clear/invert/adjust/decrement slice
// assumes the data memory model and the bound checker
`timescale 1ns/1ps
module tb_top
   import cmp_exec_pkg::*;
;
   typedef struct packed {
      logic [7:0] op;
      logic [7:0] a;
      logic [2:0] f;
      logic [7:0] ea;
      logic [2:0] ef;
   } row_type;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic instr_valid = 1'b0;
   instr_type instr = '0;
   logic [1:0] bank_register_sel = 2'h0;
   logic load_valid = 1'b0;
   logic [7:0] load_acc = 8'h00;
   program_flags_word_type load_flags = '0;
   logic [15:0] load_pc = 16'h0000;
   logic instr_ready, done, unsupported;
   mem_req_type mem_req;
   logic [7:0] mem_rdata, acc;
   program_flags_word_type flags;
   logic [15:0] pc;
   int err_total = 0;
   int n_tests = 0;
   int cycles = 0;
   int lat;
   logic seen_unsup = 1'b0;
   row_type rows [12] = '{'{8'he4, 8'h5c, 3'b101, 8'h00, 3'b101}, '{8'hf4, 8'h5c, 3'b010, 8'ha3, 3'b010},
      '{8'hc3, 8'h5c, 3'b111, 8'h5c, 3'b011}, '{8'hb3, 8'h5c, 3'b001, 8'h5c, 3'b101},
      '{8'hb3, 8'h5c, 3'b100, 8'h5c, 3'b000}, '{8'hd4, 8'hbe, 3'b000, 8'h24, 3'b100},
      '{8'hd4, 8'hc9, 3'b001, 8'h29, 3'b101}, '{8'hd4, 8'h11, 3'b010, 8'h17, 3'b010},
      '{8'hd4, 8'h99, 3'b100, 8'hf9, 3'b100}, '{8'hd4, 8'h00, 3'b000, 8'h00, 3'b000},
      '{8'h14, 8'h00, 3'b011, 8'hff, 3'b011}, '{8'h14, 8'h80, 3'b000, 8'h7f, 3'b000}};

   cmp_clear_cpl_bcd_dec_exec dut (.clock(clock), .reset(reset), .instr_valid(instr_valid), .instr(instr),
      .bank_register_sel(bank_register_sel), .instr_ready(instr_ready), .done(done), .unsupported(unsupported),
      .load_valid(load_valid), .load_acc(load_acc), .load_flags(load_flags), .load_pc(load_pc),
      .mem_req(mem_req), .mem_rdata(mem_rdata), .acc(acc), .flags(flags), .pc(pc));
   data_mem_model u_mem (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));

   always #2.5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic load_state(input logic [7:0] a, input logic [2:0] f, input logic [15:0] p);
      @(negedge clock);
      load_valid = 1'b1;
      load_acc = a;
      load_flags = f;
      load_pc = p;
      @(negedge clock);
      load_valid = 1'b0;
   endtask : load_state
   // load, offer one instruction, wait for its done or unsupported pulse
   task automatic run(input logic [7:0] a, input logic [2:0] f, input logic [15:0] p, input instr_type w);
      int n;
      n = 0;
      load_state(a, f, p);
      while (instr_ready !== 1'b1 && n < 50) begin
         n++;
         @(negedge clock);
      end
      instr = w;
      instr_valid = 1'b1;
      @(negedge clock);
      instr_valid = 1'b0;
      lat = 1;
      while (done !== 1'b1 && unsupported !== 1'b1 && lat < 20) begin
         lat++;
         @(negedge clock);
      end
      seen_unsup = unsupported;
      // memory write issued on the done cycle lands at the next edge
      @(negedge clock);
   endtask : run
   task tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : tally_and_finish

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clock);
      @(negedge clock);
      reset = 1'b0;
      @(negedge clock);
      check("reset state", {acc, 5'h00, flags}, 16'h0000);
      check("reset pc", pc, PC_RESET);
      check("ready after reset", {15'h0000, instr_ready}, 16'h0001);
      for (int i = 0; i < 12; i++) begin
         run(rows[i].a, rows[i].f, 16'h0100, {rows[i].op, 16'h0000});
         check("acc", {8'h00, acc}, {8'h00, rows[i].ea});
         check("flags", {13'h0000, flags}, {13'h0000, rows[i].ef});
         check("single pc", pc, 16'h0101);
         check("single latency", lat[15:0], 16'h0001);
      end
      run(8'h34, 3'b011, 16'h1000, {8'hb4, 8'h60, 8'hfc});
      check("cmp imm less", {acc, 7'h00, flags.carry_flag}, 16'h3401);
      check("cmp imm pc", pc, 16'h0fff);
      run(8'h34, 3'b100, 16'h1000, {8'hb4, 8'h34, 8'h10});
      check("cmp imm equal", {pc[7:0], 7'h00, flags.carry_flag}, 16'h0300);
      u_mem.ram[8'h40] = 8'h35;
      run(8'h34, 3'b000, 16'h2000, {8'hb5, 8'h40, 8'h10});
      check("cmp direct", {pc[7:0], u_mem.ram[8'h40]}, 16'h1335);
      check("cmp direct latency", lat[15:0], 16'h0004);
      bank_register_sel = 2'h1;
      u_mem.ram[8'h0f] = 8'h56;
      run(8'h00, 3'b000, 16'h2000, {8'hbf, 8'h60, 8'h02});
      check("cmp reg", {pc[7:0], 7'h00, flags.carry_flag}, 16'h0501);
      u_mem.ram[8'h0b] = 8'h00;
      run(8'h00, 3'b000, 16'h2000, {8'h1b, 16'h0000});
      check("dec reg", {pc[7:0], u_mem.ram[8'h0b]}, 16'h01ff);
      bank_register_sel = 2'h0;
      u_mem.ram[8'h01] = 8'h50;
      u_mem.ram[8'h50] = 8'h70;
      run(8'h00, 3'b100, 16'h2000, {8'hb7, 8'h60, 8'h80});
      check("cmp ind", {pc[7:0], 7'h00, flags.carry_flag}, 16'h8300);
      check("cmp ind pc high", {8'h00, pc[15:8]}, 16'h001f);
      check("cmp ind latency", lat[15:0], 16'h0006);
      u_mem.ram[8'h00] = 8'h7f;
      u_mem.ram[8'h7f] = 8'h40;
      run(8'h00, 3'b000, 16'h2000, {8'h16, 16'h0000});
      check("dec ind", {lat[7:0], u_mem.ram[8'h7f]}, 16'h053f);
      u_mem.ram[8'h90] = 8'h5d;
      run(8'h00, 3'b101, 16'h2000, {8'hc2, 8'h92, 8'h00});
      check("clr bit", {pc[7:0], u_mem.ram[8'h90]}, 16'h0259);
      check("clr bit flags", {13'h0000, flags}, 16'h0005);
      run(8'h00, 3'b010, 16'h2000, {8'hb2, 8'h91, 8'h00});
      check("inv bit", {lat[7:0], u_mem.ram[8'h90]}, 16'h035b);
      run(8'h00, 3'b010, 16'h2000, {8'h15, 8'h90, 8'h00});
      check("dec port", {pc[7:0], u_mem.ram[8'h90]}, 16'h025a);
      run(8'h77, 3'b000, 16'h3000, {8'h00, 16'h0000});
      check("unsupported", {acc, pc[7:0]}, 16'h7700);
      check("unsupported pulse", {15'h0000, seen_unsup}, 16'h0001);
      tally_and_finish();
   end
endmodule : tb_top
